/* File: asd_cls_if.sv */
`timescale 1ns/1ps
interface asd_cls_if;
	logic [7:0] opc;
	asd_pkg::asd_kind_e kind;
	asd_pkg::asd_op_e op;
	logic w;
	logic z;

	modport cls (input opc, output kind, output op, output w, output z);
	modport user (output opc, input kind, input op, input w, input z);
endinterface : asd_cls_if

/* File: asd_exec_model.sv */
`timescale 1ns/1ps
// execution unit side: takes results, but may stall for any number of cycles
module asd_exec_model (
	input wire logic sys_clk_i,
	input wire logic stall_i,
	output logic out_ready_o
);
	initial out_ready_o = 1'b0;
	always @(negedge sys_clk_i) out_ready_o <= !stall_i;
endmodule : asd_exec_model

/* File: asd_first_byte.sv */
`timescale 1ns/1ps
// classifies the first byte alone; operand bytes are resolved by the sequencer
module asd_first_byte (
	asd_cls_if.cls cls
);
	assign cls.w = cls.opc[asd_pkg::W_BIT]; // [RULE21]
	assign cls.z = cls.opc[asd_pkg::W_BIT]; // [RULE18]

	always_comb begin
		cls.kind = asd_pkg::k_single;
		cls.op = asd_pkg::illegal_op;
		casez (cls.opc)
			asd_pkg::OPC_AAA: cls.op = asd_pkg::unpacked_add_adjust_op; // [RULE5]
			asd_pkg::OPC_DAA: cls.op = asd_pkg::packed_add_adjust_op; // [RULE6]
			asd_pkg::OPC_AAS: cls.op = asd_pkg::unpacked_sub_adjust_op; // [RULE7]
			asd_pkg::OPC_DAS: cls.op = asd_pkg::packed_sub_adjust_op; // [RULE8]
			asd_pkg::OPC_ALU_RM: begin // [RULE1] [RULE2] [RULE3] [RULE4] [RULE16]
				cls.kind = asd_pkg::k_alu_rm;
				cls.op = asd_pkg::alu_op(cls.opc[asd_pkg::EXT_MSB:asd_pkg::EXT_LSB]);
			end
			asd_pkg::OPC_ALU_ACC: begin // [RULE1] [RULE2] [RULE3] [RULE4] [RULE16]
				cls.kind = asd_pkg::k_acc_imm;
				cls.op = asd_pkg::alu_op(cls.opc[asd_pkg::EXT_MSB:asd_pkg::EXT_LSB]);
			end
			asd_pkg::OPC_INC_REG: cls.op = asd_pkg::inc_op; // [RULE25]
			asd_pkg::OPC_DEC_REG: cls.op = asd_pkg::dec_op; // [RULE25]
			asd_pkg::OPC_IMM_GRP: cls.kind = asd_pkg::k_imm_grp; // [RULE1]
			asd_pkg::OPC_TEST_RM: begin
				cls.kind = asd_pkg::k_alu_rm;
				cls.op = asd_pkg::test_op;
			end
			asd_pkg::OPC_CBW: cls.op = asd_pkg::byte_to_word_extend_op; // [RULE13]
			asd_pkg::OPC_CWD: cls.op = asd_pkg::word_to_dword_extend_op; // [RULE13]
			asd_pkg::OPC_CALL_FAR: begin // [RULE24]
				cls.kind = asd_pkg::k_call_far;
				cls.op = asd_pkg::far_call_op;
			end
			asd_pkg::OPC_BLOCK_MOVE_OP: cls.op = asd_pkg::block_move_op; // [RULE18]
			asd_pkg::OPC_STRING_COMPARE_OP: cls.op = asd_pkg::string_compare_op; // [RULE19]
			asd_pkg::OPC_STRING_SCAN_OP: cls.op = asd_pkg::string_scan_op; // [RULE19]
			asd_pkg::OPC_STRING_LOAD_OP: cls.op = asd_pkg::string_load_op; // [RULE20]
			asd_pkg::OPC_STRING_STORE_OP: cls.op = asd_pkg::string_store_op; // [RULE20]
			asd_pkg::OPC_TEST_ACC: begin // [RULE17]
				cls.kind = asd_pkg::k_acc_imm;
				cls.op = asd_pkg::test_op;
			end
			asd_pkg::OPC_SHIFT: cls.kind = asd_pkg::k_shift_grp; // [RULE15]
			asd_pkg::OPC_AAM: begin // [RULE11]
				cls.kind = asd_pkg::k_adjust2;
				cls.op = asd_pkg::unpacked_mult_adjust_op;
			end
			asd_pkg::OPC_AAD: begin // [RULE12]
				cls.kind = asd_pkg::k_adjust2;
				cls.op = asd_pkg::unpacked_div_adjust_op;
			end
			asd_pkg::OPC_CALL_NEAR: begin // [RULE24]
				cls.kind = asd_pkg::k_call_near;
				cls.op = asd_pkg::near_call_op;
			end
			asd_pkg::OPC_REP: cls.kind = asd_pkg::k_prefix; // [RULE18]
			asd_pkg::OPC_UNARY: cls.kind = asd_pkg::k_unary_grp;
			asd_pkg::OPC_EXT: cls.kind = asd_pkg::k_ext_grp; // [RULE25]
			default: cls.kind = asd_pkg::k_illegal;
		endcase
	end
endmodule : asd_first_byte

/* File: asd_opcode_decoder.sv */
`timescale 1ns/1ps
module asd_opcode_decoder (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	input wire logic [7:0] in_byte_i,
	output logic in_ready_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output asd_pkg::asd_op_e op_o,
	output logic word_o,
	output logic dir_o,
	output logic sign_ext_o,
	output logic count_cl_o,
	output logic [1:0] mod_o,
	output logic [2:0] reg_o,
	output logic [2:0] rm_o,
	output logic rm_is_reg_o,
	output logic [15:0] disp_o,
	output logic [15:0] imm_o,
	output logic [15:0] seg_o,
	output logic rep_o,
	output logic rep_z_o
);
	asd_cls_if cls_bus ();

	asd_first_byte u_first (
		.cls(cls_bus)
	);

	asd_pkg::asd_state_e st_q, st_d;
	asd_pkg::asd_kind_e kind_q, kind_d;
	asd_pkg::asd_op_e op_q, op_d;
	logic w_q, w_d, d_q, d_d, s_q, s_d, v_q, v_d;
	logic [7:0] modrm_q, modrm_d;
	logic [15:0] disp_q, disp_d, imm_q, imm_d, seg_q, seg_d;
	logic [1:0] disp_n_q, disp_n_d, imm_n_q, imm_n_d;
	logic rep_pend_q, rep_pend_d, rep_zp_q, rep_zp_d, rep_q, rep_d, rep_z_q, rep_z_d;
	logic out_valid_q, out_valid_d;
	logic done;

	wire accept = in_valid_i && in_ready_o;
	wire [1:0] mod_in = in_byte_i[asd_pkg::MOD_MSB:asd_pkg::MOD_LSB];
	wire [2:0] rm_in = in_byte_i[asd_pkg::RM_MSB:asd_pkg::RM_LSB];
	wire [2:0] ext_in = in_byte_i[asd_pkg::EXT_MSB:asd_pkg::EXT_LSB];
	wire [7:0] sext_hi = {8{in_byte_i[7]}};

	assign cls_bus.opc = in_byte_i;
	// a stalled result blocks the queue; the byte in flight is never dropped
	assign in_ready_o = !out_valid_q || out_ready_i;

	// displacement length from mod and rm of the incoming mod/reg/rm byte
	wire disp_two = (mod_in == asd_pkg::MOD_DISP16) ||
		(mod_in == asd_pkg::MOD_NO_DISP && rm_in == asd_pkg::RM_DIRECT);
	wire [1:0] disp_need = (mod_in == asd_pkg::MOD_DISP8) ? asd_pkg::CNT_ONE : // [RULE23]
		disp_two ? asd_pkg::CNT_TWO : asd_pkg::CNT_NONE; // [RULE22]

	// operation chosen by the extension field for the grouped opcodes
	logic grp_op_ok;
	asd_pkg::asd_op_e unary_op, shift_op, ext_op, grp_op;
	always_comb begin
		case (ext_in) // [RULE9] [RULE10] [RULE14]
			3'h0: unary_op = asd_pkg::test_op;
			3'h2: unary_op = asd_pkg::invert_op;
			3'h3: unary_op = asd_pkg::negate_op;
			3'h4: unary_op = asd_pkg::multiply_op;
			3'h5: unary_op = asd_pkg::signed_multiply_op;
			3'h6: unary_op = asd_pkg::divide_op;
			3'h7: unary_op = asd_pkg::signed_divide_op;
			default: unary_op = asd_pkg::illegal_op;
		endcase
	end
	always_comb begin
		case (ext_in) // [RULE15]
			3'h0: shift_op = asd_pkg::rotate_left_op;
			3'h1: shift_op = asd_pkg::rotate_right_op;
			3'h2: shift_op = asd_pkg::carry_rotate_left_op;
			3'h3: shift_op = asd_pkg::carry_rotate_right_op;
			3'h4: shift_op = asd_pkg::shift_left_op;
			3'h5: shift_op = asd_pkg::logic_right_shift_op;
			3'h7: shift_op = asd_pkg::arith_right_shift_op;
			default: shift_op = asd_pkg::illegal_op;
		endcase
	end
	// indirect calls exist only in the word form of the inc/dec group
	always_comb begin
		case (ext_in) // [RULE24] [RULE25]
			3'h0: ext_op = asd_pkg::inc_op;
			3'h1: ext_op = asd_pkg::dec_op;
			3'h2: ext_op = w_q ? asd_pkg::near_call_ind_op : asd_pkg::illegal_op;
			3'h3: ext_op = w_q ? asd_pkg::far_call_ind_op : asd_pkg::illegal_op;
			default: ext_op = asd_pkg::illegal_op;
		endcase
	end
	assign grp_op_ok = (kind_q == asd_pkg::k_imm_grp);
	assign grp_op = grp_op_ok ? asd_pkg::alu_op(ext_in) : // [RULE1] [RULE2] [RULE3] [RULE4] [RULE16]
		(kind_q == asd_pkg::k_unary_grp) ? unary_op :
		(kind_q == asd_pkg::k_shift_grp) ? shift_op :
		(kind_q == asd_pkg::k_ext_grp) ? ext_op : op_q;

	// immediate bytes following the mod/reg/rm byte
	wire imm_grp_two = ({s_q, w_q} == 2'b01);
	wire unary_test = (kind_q == asd_pkg::k_unary_grp) && (ext_in == asd_pkg::EXT_TEST);
	wire [1:0] w_count = w_q ? asd_pkg::CNT_TWO : asd_pkg::CNT_ONE;
	wire [1:0] grp_imm = grp_op_ok ? (imm_grp_two ? asd_pkg::CNT_TWO : asd_pkg::CNT_ONE) : // [RULE1]
		unary_test ? w_count : asd_pkg::CNT_NONE; // [RULE14]
	wire [1:0] acc_count = cls_bus.w ? asd_pkg::CNT_TWO : asd_pkg::CNT_ONE; // [RULE16] [RULE17]
	wire after_disp_data = (imm_n_q != asd_pkg::CNT_NONE);
	wire imm_sext = s_q && grp_op_ok;

	always_comb begin
		st_d = st_q;
		kind_d = kind_q;
		op_d = op_q;
		w_d = w_q;
		d_d = d_q;
		s_d = s_q;
		v_d = v_q;
		modrm_d = modrm_q;
		disp_d = disp_q;
		imm_d = imm_q;
		seg_d = seg_q;
		disp_n_d = disp_n_q;
		imm_n_d = imm_n_q;
		rep_pend_d = rep_pend_q;
		rep_zp_d = rep_zp_q;
		rep_d = rep_q;
		rep_z_d = rep_z_q;
		done = 1'b0;
		if (accept) begin
			case (st_q)
				asd_pkg::st_opcode: begin
					if (cls_bus.kind == asd_pkg::k_prefix) begin
						rep_pend_d = 1'b1; // [RULE18]
						rep_zp_d = cls_bus.z; // [RULE18]
					end else begin
						kind_d = cls_bus.kind;
						op_d = cls_bus.op;
						w_d = cls_bus.w; // [RULE21]
						d_d = in_byte_i[asd_pkg::D_BIT];
						s_d = in_byte_i[asd_pkg::D_BIT];
						v_d = in_byte_i[asd_pkg::D_BIT];
						// one-byte register forms report their register as a mod 11 operand
						modrm_d = {asd_pkg::MOD_REG, 3'h0, rm_in}; // [RULE25]
						disp_d = asd_pkg::FIELD_RST;
						imm_d = asd_pkg::FIELD_RST;
						seg_d = asd_pkg::FIELD_RST;
						disp_n_d = asd_pkg::CNT_NONE;
						imm_n_d = asd_pkg::CNT_NONE;
						rep_d = rep_pend_q; // [RULE18]
						// a z bit left over from an earlier prefix must not leak
						rep_z_d = rep_pend_q && rep_zp_q; // [RULE18]
						rep_pend_d = 1'b0;
						case (cls_bus.kind)
							asd_pkg::k_alu_rm, asd_pkg::k_imm_grp, asd_pkg::k_unary_grp,
							asd_pkg::k_shift_grp, asd_pkg::k_ext_grp: st_d = asd_pkg::st_modrm;
							asd_pkg::k_acc_imm: begin
								imm_n_d = acc_count; // [RULE16] [RULE17]
								st_d = asd_pkg::st_data_lo;
							end
							asd_pkg::k_adjust2: begin
								imm_n_d = asd_pkg::CNT_ONE; // [RULE11] [RULE12]
								st_d = asd_pkg::st_data_lo;
							end
							asd_pkg::k_call_near: begin
								disp_n_d = asd_pkg::CNT_TWO; // [RULE24]
								st_d = asd_pkg::st_disp_lo;
							end
							asd_pkg::k_call_far: begin
								imm_n_d = asd_pkg::CNT_TWO; // [RULE24]
								st_d = asd_pkg::st_data_lo;
							end
							default: done = 1'b1; // [RULE5] [RULE6] [RULE7] [RULE8] [RULE13]
						endcase
					end
				end
				asd_pkg::st_modrm: begin
					modrm_d = in_byte_i;
					op_d = grp_op;
					disp_n_d = disp_need;
					imm_n_d = grp_imm;
					if (disp_need != asd_pkg::CNT_NONE) begin
						st_d = asd_pkg::st_disp_lo;
					end else if (grp_imm != asd_pkg::CNT_NONE) begin
						st_d = asd_pkg::st_data_lo; // [RULE22]
					end else begin
						done = 1'b1;
					end
				end
				asd_pkg::st_disp_lo: begin
					if (disp_n_q == asd_pkg::CNT_ONE) begin
						disp_d = {sext_hi, in_byte_i}; // [RULE23]
						st_d = after_disp_data ? asd_pkg::st_data_lo : asd_pkg::st_opcode;
						done = !after_disp_data;
					end else begin
						disp_d = {8'h00, in_byte_i};
						st_d = asd_pkg::st_disp_hi;
					end
				end
				asd_pkg::st_disp_hi: begin
					disp_d = {in_byte_i, disp_q[7:0]};
					st_d = after_disp_data ? asd_pkg::st_data_lo : asd_pkg::st_opcode;
					done = !after_disp_data;
				end
				asd_pkg::st_data_lo: begin
					imm_d = {imm_sext ? sext_hi : 8'h00, in_byte_i};
					// a wrong fixed second byte turns the adjust into an illegal opcode
					if (kind_q == asd_pkg::k_adjust2 && in_byte_i != asd_pkg::ADJ_SECOND_BYTE) begin
						op_d = asd_pkg::illegal_op; // [RULE11] [RULE12]
					end
					if (imm_n_q == asd_pkg::CNT_ONE) begin
						done = 1'b1;
					end else begin
						st_d = asd_pkg::st_data_hi;
					end
				end
				asd_pkg::st_data_hi: begin
					imm_d = {in_byte_i, imm_q[7:0]};
					if (kind_q == asd_pkg::k_call_far) begin
						st_d = asd_pkg::st_seg_lo; // [RULE24]
					end else begin
						done = 1'b1;
					end
				end
				asd_pkg::st_seg_lo: begin
					seg_d = {8'h00, in_byte_i};
					st_d = asd_pkg::st_seg_hi;
				end
				asd_pkg::st_seg_hi: begin
					seg_d = {in_byte_i, seg_q[7:0]};
					done = 1'b1;
				end
				default: st_d = asd_pkg::st_opcode;
			endcase
		end
		if (done) begin
			st_d = asd_pkg::st_opcode;
		end
		out_valid_d = done || (out_valid_q && !out_ready_i);
		// a queue flush abandons the partial instruction and any pending prefix
		if (flush_i) begin
			st_d = asd_pkg::st_opcode;
			rep_pend_d = 1'b0;
			out_valid_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= asd_pkg::st_opcode;
			kind_q <= asd_pkg::k_illegal;
			op_q <= asd_pkg::illegal_op;
			{w_q, d_q, s_q, v_q} <= 4'h0;
			modrm_q <= 8'h00;
			disp_q <= asd_pkg::FIELD_RST;
			imm_q <= asd_pkg::FIELD_RST;
			seg_q <= asd_pkg::FIELD_RST;
			disp_n_q <= asd_pkg::CNT_NONE;
			imm_n_q <= asd_pkg::CNT_NONE;
			{rep_pend_q, rep_zp_q, rep_q, rep_z_q} <= 4'h0;
			out_valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			kind_q <= kind_d;
			op_q <= op_d;
			{w_q, d_q, s_q, v_q} <= {w_d, d_d, s_d, v_d};
			modrm_q <= modrm_d;
			disp_q <= disp_d;
			imm_q <= imm_d;
			seg_q <= seg_d;
			disp_n_q <= disp_n_d;
			imm_n_q <= imm_n_d;
			{rep_pend_q, rep_zp_q, rep_q, rep_z_q} <= {rep_pend_d, rep_zp_d, rep_d, rep_z_d};
			out_valid_q <= out_valid_d;
		end
	end

	assign out_valid_o = out_valid_q;
	assign op_o = op_q;
	assign word_o = w_q;
	assign dir_o = d_q;
	assign sign_ext_o = s_q;
	assign count_cl_o = v_q;
	assign mod_o = modrm_q[asd_pkg::MOD_MSB:asd_pkg::MOD_LSB];
	assign reg_o = modrm_q[asd_pkg::EXT_MSB:asd_pkg::EXT_LSB];
	assign rm_o = modrm_q[asd_pkg::RM_MSB:asd_pkg::RM_LSB];
	assign rm_is_reg_o = (mod_o == asd_pkg::MOD_REG); // [RULE22]
	assign disp_o = disp_q;
	assign imm_o = imm_q;
	assign seg_o = seg_q;
	assign rep_o = rep_q;
	assign rep_z_o = rep_z_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	wire first_acc = accept && (st_q == asd_pkg::st_opcode) && !flush_i;

	a_add_unpacked_adj: assert property (first_acc && in_byte_i == asd_pkg::OPC_AAA // [RULE5]
		|=> out_valid_o && op_o == asd_pkg::unpacked_add_adjust_op)
		else $error("unpacked add adjust not decoded as one byte");
	a_add_packed_adj: assert property (first_acc && in_byte_i == asd_pkg::OPC_DAA // [RULE6]
		|=> out_valid_o && op_o == asd_pkg::packed_add_adjust_op)
		else $error("packed add adjust not decoded as one byte");
	a_sub_unpacked_adj: assert property (first_acc && in_byte_i == asd_pkg::OPC_AAS // [RULE7]
		|=> out_valid_o && op_o == asd_pkg::unpacked_sub_adjust_op && st_q == asd_pkg::st_opcode)
		else $error("unpacked subtract adjust not decoded as one byte");
	a_sub_packed_adj: assert property (first_acc && in_byte_i == asd_pkg::OPC_DAS // [RULE8]
		|=> out_valid_o && op_o == asd_pkg::packed_sub_adjust_op && st_q == asd_pkg::st_opcode)
		else $error("packed subtract adjust not decoded as one byte");
	a_width_bit_word: assert property (first_acc && cls_bus.kind != asd_pkg::k_prefix // [RULE21]
		|=> word_o == $past(in_byte_i[0]))
		else $error("width bit not carried to word output");
	a_reg_mode_nodisp: assert property (accept && !flush_i && st_q == asd_pkg::st_modrm && // [RULE22]
		mod_in == asd_pkg::MOD_REG |=> st_q != asd_pkg::st_disp_lo && rm_is_reg_o)
		else $error("register mode fetched a displacement");
	a_short_disp_sext: assert property (accept && st_q == asd_pkg::st_disp_lo && // [RULE23]
		disp_n_q == asd_pkg::CNT_ONE |=> disp_o == {{8{$past(in_byte_i[7])}}, $past(in_byte_i)})
		else $error("one-byte displacement not sign extended");
	a_imm_word_count: assert property (accept && !flush_i && st_q == asd_pkg::st_modrm && // [RULE1]
		kind_q == asd_pkg::k_imm_grp && imm_grp_two |=> imm_n_q == asd_pkg::CNT_TWO)
		else $error("s:w 01 immediate must take two data bytes");
	a_adjust_check: assert property (accept && st_q == asd_pkg::st_data_lo && // [RULE11]
		kind_q == asd_pkg::k_adjust2 && in_byte_i != asd_pkg::ADJ_SECOND_BYTE
		|=> out_valid_o && op_o == asd_pkg::illegal_op)
		else $error("adjust with wrong second byte not flagged");
	a_far_call_seg: assert property (accept && !flush_i && st_q == asd_pkg::st_data_hi && // [RULE24]
		kind_q == asd_pkg::k_call_far |=> st_q == asd_pkg::st_seg_lo ##1 !out_valid_o || st_q !=
		asd_pkg::st_seg_lo)
		else $error("far call did not go on to segment bytes");
	a_rep_attaches: assert property (first_acc && rep_pend_q && // [RULE18]
		in_byte_i == 8'ha4 |=> out_valid_o && rep_o && op_o == asd_pkg::block_move_op)
		else $error("repeat prefix not attached to block move");
	a_stall_holds: assert property (out_valid_o && !out_ready_i && !flush_i
		|=> out_valid_o && $stable(op_o) && $stable(imm_o) && in_ready_o == out_ready_i)
		else $error("result changed while stalled");

	c_far_call: cover property (out_valid_o && op_o == asd_pkg::far_call_op);
	c_rep_string: cover property (out_valid_o && rep_o && op_o == asd_pkg::string_scan_op);
	c_disp_and_imm: cover property (st_q == asd_pkg::st_disp_hi ##1 st_q == asd_pkg::st_data_lo);
	c_back_to_back: cover property (out_valid_o && out_ready_i ##1 out_valid_o);
endmodule : asd_opcode_decoder

/* File: asd_opcode_decoder_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end end
module asd_opcode_decoder_tb;
	typedef struct {asd_pkg::asd_op_e op; logic w, dr, repeat_prefix, z, cd, ci; logic [7:0] mr;
		logic [15:0] d, i, s;} asd_exp_s;
	logic sys_clk_i = 0, arst_n_i = 0, in_valid_i = 0, stall = 1, out_ready_i, took = 0, pend = 0, pz = 0;
	logic [7:0] in_byte_i = 8'h00;
	logic in_ready_o, out_valid_o, word_o, rep_o, rep_z_o;
	logic dir_o, sign_ext_o, count_cl_o, rm_is_reg_o;
	logic [1:0] mod_o;
	logic [2:0] reg_o, rm_o;
	asd_pkg::asd_op_e op_o;
	logic [15:0] disp_o, imm_o, seg_o;
	logic [31:0] rs = 32'h000161f1, r;
	int fails = 0, cmp_count = 0, cyc = 0;
	asd_exp_s eq[$], e;
	logic [7:0] bq[$];
	always #10 sys_clk_i = ~sys_clk_i;
	asd_opcode_decoder dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .flush_i(1'b0),
		.in_valid_i(in_valid_i), .in_byte_i(in_byte_i), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .op_o(op_o), .word_o(word_o),
		.dir_o(dir_o), .sign_ext_o(sign_ext_o), .count_cl_o(count_cl_o), .mod_o(mod_o),
		.reg_o(reg_o), .rm_o(rm_o), .rm_is_reg_o(rm_is_reg_o),
		.disp_o(disp_o), .imm_o(imm_o), .seg_o(seg_o), .rep_o(rep_o), .rep_z_o(rep_z_o));
	asd_exec_model exu (.sys_clk_i(sys_clk_i), .stall_i(stall), .out_ready_o(out_ready_i));
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	function automatic asd_pkg::asd_op_e opn(input int n);
		return asd_pkg::asd_op_e'(n);
	endfunction : opn
	task automatic gen();
		logic [7:0] o, m;
		logic [15:0] dd, ii;
		logic [31:0] q;
		int nd, ni, hm;
		asd_exp_s x;
		q = rnd();
		ii = rnd();
		{dd, m, o} = q;
		nd = 0;
		ni = 0;
		hm = 0;
		if (ii[15:12] == 0) o = {7'h79, ii[11]};
		x.op = asd_pkg::illegal_op;
		if (o[7:6] == 0 && o[2:1] < 2) begin x.op = opn(o[5:3]); hm = 1; end
		else if (o[7:6] == 0 && o[2:1] == 2) begin x.op = opn(o[5:3]); ni = 1 + o[0]; end
		else if (o inside {8'h27, 8'h2f, 8'h37, 8'h3f}) x.op = opn(24 + {o[3], ~o[4]});
		else if (o[7:4] == 4) x.op = o[3] ? asd_pkg::dec_op : asd_pkg::inc_op;
		else if (o[7:2] == 6'h20) begin x.op = opn(m[5:3]); hm = 1; ni = o[1:0] == 1 ? 2 : 1; end
		else if (o[7:1] == 7'h4c) x.op = opn(30 + o[0]);
		else if (o == 8'h9a) begin x.op = asd_pkg::far_call_op; ni = 2; end
		else if (o[7:4] == 4'ha && o[3:2] != 0) begin
			x.op = opn(o[3:1] == 4 ? 8 : 30 + o[3:1] +
				(o[3:1] == 5 ? 1 : o[3:1] == 6 ? -1 : o[3:1] == 7 ? -3 : 0));
			if (o[3:1] == 4) ni = 1 + o[0];
		end
		else if (o[7:2] == 6'h34) begin
			if (m[5:3] == 6) m[5:3] = 7;
			x.op = opn(17 + (m[5:3] == 7 ? 6 : m[5:3]));
			hm = 1;
		end
		else if (o[7:1] == 7'h6a) begin x.op = opn(28 + o[0]); ni = 1; ii = 16'h000a; end
		else if (o == 8'he8) begin x.op = asd_pkg::near_call_op; nd = 2; end
		else if (o[7:1] == 7'h7b) begin
			if (m[5:3] == 1) m[5:3] = 0;
			x.op = opn(m[5:3] == 0 ? 8 : m[5:3] == 2 ? 12 : m[5:3] == 3 ? 11 : 9 + m[5:3]);
			if (m[5:3] == 0) ni = 1 + o[0];
			hm = 1;
		end
		else if (o[7:1] == 7'h7f) begin
			m[5:3] = m[5:3] & (o[0] ? 3'h3 : 3'h1);
			x.op = opn(m[5:3] < 2 ? 9 + m[5:3] : 37 + m[5:3]);
			hm = 1;
		end
		else if (o[7:1] == 7'h79) begin bq.push_back(o); pend = 1; pz = o[0]; return; end
		else o = 8'hf4;
		bq.push_back(o);
		if (hm) begin
			bq.push_back(m);
			nd = m[7:6] == 1 ? 1 : (m[7:6] == 2 || (m[7:6] == 0 && m[2:0] == 6)) ? 2 : 0;
		end
		for (int k = 0; k < nd; k++) bq.push_back(dd[8*k+:8]);
		for (int k = 0; k < ni; k++) bq.push_back(ii[8*k+:8]);
		if (o == 8'h9a) begin bq.push_back(dd[7:0]); bq.push_back(dd[15:8]); end
		x.w = o[0];
		x.dr = o[1];
		x.mr = hm ? m : {5'h18, o[2:0]};
		x.cd = nd > 0;
		x.d = nd == 1 ? {{8{dd[7]}}, dd[7:0]} : dd;
		x.ci = ni > 0;
		x.i = ni == 1 ? {(o[7:1] == 7'h41) ? {8{ii[7]}} : 8'h00, ii[7:0]} : ii;
		x.s = o == 8'h9a ? dd : 16'h0000;
		x.repeat_prefix = pend;
		x.z = pz;
		pend = 0;
		pz = 0;
		eq.push_back(x);
	endtask : gen
	task automatic final_report();
		if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	always @(negedge sys_clk_i) begin
		r = rnd();
		stall <= r[1:0] == 0;
		if (!in_valid_i || took) begin
			in_valid_i <= bq.size() > 0 && r[4:2] != 0;
			in_byte_i <= bq.size() > 0 ? bq[0] : r[15:8];
		end
		took = 0;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc > 30000) begin fails++; final_report(); end
		if (in_valid_i && in_ready_o === 1'b1) begin void'(bq.pop_front()); took = 1; end
		if (arst_n_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
			if (eq.size() == 0) `CHK("extra", 1'b0, 1'b1)
			else begin
				e = eq.pop_front();
				`CHK("op", e.op, op_o)
				`CHK("word", e.w, word_o)
				`CHK("dir", {3{e.dr}}, {dir_o, sign_ext_o, count_cl_o})
				`CHK("modrm", e.mr, {mod_o, reg_o, rm_o})
				`CHK("regmode", e.mr[7:6] == 2'h3, rm_is_reg_o)
				`CHK("rep", {e.repeat_prefix, e.z}, {rep_o, rep_z_o})
				`CHK("seg", e.s, seg_o)
				if (e.cd) `CHK("disp", e.d, disp_o)
				if (e.ci) `CHK("imm", e.i, imm_o)
			end
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk_i);
		@(negedge sys_clk_i) arst_n_i = 1;
		repeat (600) gen();
		while (eq.size() > 0 || bq.size() > 0) @(posedge sys_clk_i);
		repeat (4) @(posedge sys_clk_i);
		final_report();
	end
endmodule : asd_opcode_decoder_tb

/* File: asd_pkg.sv */
// Functional notes
// [RULE1] add forms: register, immediate group, accumulator
// [RULE2] add-with-carry forms, immediate extension 010
// [RULE3] subtract forms, immediate extension 101
// [RULE4] subtract-with-borrow forms, immediate extension 011
// [RULE5] 37h is unpacked add adjust, one byte
// [RULE6] 27h is packed add adjust, one byte
// [RULE7] 3fh is unpacked subtract adjust, one byte
// [RULE8] 2fh is packed subtract adjust, one byte
// [RULE9] f6/f7 extension 100/101: unsigned/signed multiply
// [RULE10] f6/f7 extension 110/111: unsigned/signed divide
// [RULE11] d4h then 0ah: multiply adjust, two bytes
// [RULE12] d5h then 0ah: divide adjust, two bytes
// [RULE13] 98h byte-to-word, 99h word-to-dword extend
// [RULE14] f6/f7 extension 000 test, 010 invert, 011 negate
// [RULE15] d0-d3 shift group selected by extension
// [RULE16] and forms; accumulator immediate takes w bytes
// [RULE17] a8/a9 test accumulator with immediate data
// [RULE18] block move and repeat prefix with z bit
// [RULE19] string compare and string scan opcodes
// [RULE20] string load and string store opcodes
// [RULE21] width bit one means word operation
// [RULE22] mod 11: register operand, no displacement
// [RULE23] mod 01: one displacement byte, sign extended
// [RULE24] near, far and indirect subroutine calls
// [RULE25] register and register-or-memory increment, decrement
package asd_pkg;
	typedef enum logic [5:0] {
		add_op, or_op, add_carry_op, subtract_with_borrow_op,
		and_op, sub_op, xor_op, compare_op,
		test_op, inc_op, dec_op, negate_op, invert_op,
		multiply_op, signed_multiply_op, divide_op, signed_divide_op,
		rotate_left_op, rotate_right_op, carry_rotate_left_op, carry_rotate_right_op,
		shift_left_op, logic_right_shift_op, arith_right_shift_op,
		unpacked_add_adjust_op, packed_add_adjust_op, unpacked_sub_adjust_op,
		packed_sub_adjust_op, unpacked_mult_adjust_op, unpacked_div_adjust_op,
		byte_to_word_extend_op, word_to_dword_extend_op,
		block_move_op, string_compare_op, string_scan_op, string_load_op, string_store_op,
		near_call_op, far_call_op, near_call_ind_op, far_call_ind_op,
		illegal_op
	} asd_op_e;

	typedef enum logic [3:0] {
		k_single, k_alu_rm, k_imm_grp, k_acc_imm, k_unary_grp, k_shift_grp,
		k_ext_grp, k_adjust2, k_call_near, k_call_far, k_prefix, k_illegal
	} asd_kind_e;

	typedef enum logic [2:0] {
		st_opcode = 3'h0, st_modrm = 3'h1, st_disp_lo = 3'h3, st_disp_hi = 3'h2,
		st_data_lo = 3'h6, st_data_hi = 3'h7, st_seg_lo = 3'h5, st_seg_hi = 3'h4
	} asd_state_e;

	// first-byte patterns, ? marks operand bits
	localparam logic [7:0] OPC_DAA = 8'h27;
	localparam logic [7:0] OPC_DAS = 8'h2f;
	localparam logic [7:0] OPC_AAA = 8'h37;
	localparam logic [7:0] OPC_AAS = 8'h3f;
	localparam logic [7:0] OPC_ALU_RM = 8'b00???0??;
	localparam logic [7:0] OPC_ALU_ACC = 8'b00???10?;
	localparam logic [7:0] OPC_INC_REG = 8'b01000???;
	localparam logic [7:0] OPC_DEC_REG = 8'b01001???;
	localparam logic [7:0] OPC_IMM_GRP = 8'b100000??;
	localparam logic [7:0] OPC_TEST_RM = 8'b1000010?;
	localparam logic [7:0] OPC_CBW = 8'h98;
	localparam logic [7:0] OPC_CWD = 8'h99;
	localparam logic [7:0] OPC_CALL_FAR = 8'h9a;
	localparam logic [7:0] OPC_BLOCK_MOVE_OP = 8'b1010010?;
	localparam logic [7:0] OPC_STRING_COMPARE_OP = 8'b1010011?;
	localparam logic [7:0] OPC_TEST_ACC = 8'b1010100?;
	localparam logic [7:0] OPC_STRING_STORE_OP = 8'b1010101?;
	localparam logic [7:0] OPC_STRING_LOAD_OP = 8'b1010110?;
	localparam logic [7:0] OPC_STRING_SCAN_OP = 8'b1010111?;
	localparam logic [7:0] OPC_SHIFT = 8'b110100??;
	localparam logic [7:0] OPC_AAM = 8'hd4;
	localparam logic [7:0] OPC_AAD = 8'hd5;
	localparam logic [7:0] OPC_CALL_NEAR = 8'he8;
	localparam logic [7:0] OPC_REP = 8'b1111001?;
	localparam logic [7:0] OPC_UNARY = 8'b1111011?;
	localparam logic [7:0] OPC_EXT = 8'b1111111?;
	localparam logic [7:0] ADJ_SECOND_BYTE = 8'h0a;

	// bit positions in the opcode and mod/reg/rm bytes
	localparam int W_BIT = 0;
	localparam int D_BIT = 1;
	localparam int MOD_MSB = 7;
	localparam int MOD_LSB = 6;
	localparam int EXT_MSB = 5;
	localparam int EXT_LSB = 3;
	localparam int RM_MSB = 2;
	localparam int RM_LSB = 0;
	localparam logic [1:0] MOD_NO_DISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REG = 2'h3;
	localparam logic [2:0] RM_DIRECT = 3'h6;
	localparam logic [2:0] EXT_TEST = 3'h0;
	localparam logic [1:0] CNT_NONE = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_TWO = 2'h2;
	localparam logic [15:0] FIELD_RST = 16'h0000;

	function automatic asd_op_e alu_op(input logic [2:0] ext);
		case (ext)
			3'h0: alu_op = add_op;
			3'h1: alu_op = or_op;
			3'h2: alu_op = add_carry_op;
			3'h3: alu_op = subtract_with_borrow_op;
			3'h4: alu_op = and_op;
			3'h5: alu_op = sub_op;
			3'h6: alu_op = xor_op;
			default: alu_op = compare_op;
		endcase
	endfunction : alu_op
endpackage : asd_pkg
